// File: src/ictim_top.sv
`timescale 1ns/100ps
// What this block does
// - all narrow instructions accepted except compare-branch zero/nonzero and if-then
// - only six wide instructions: branch-link, three barriers, special read/write
// - counts assume zero wait memory; stalls lengthen execution
// - moves, arithmetic, compares, logic, shifts, rotate, multiply take one cycle; moves and adds to pc take two
// - stack pointer adds and address forming take one cycle
// - single loads/stores take two cycles on bus, one on I/O port
// - sign-extending loads are register-offset only, same two-or-one timing
// - multiple transfers, push and pop take one plus list length
// - link register in push or pc in pop counts in list length
// - conditional branch takes two if taken, one if not
// - branch, exchange, register link-exchange take two; immediate branch-link three
// - byte/halfword extend takes one cycle
// - byte reversals take one cycle
// - wait hints take two cycles excluding waiting
// - supervisor call and breakpoint have no fixed count
module ictim_top
  import ictim_pkg::*;
(
  // ----------------------------------------------------------------
  // clock and reset
  // ----------------------------------------------------------------
  input  wire logic                 clock,
  input  wire logic                 rst,
  // ----------------------------------------------------------------
  // instruction issue
  // ----------------------------------------------------------------
  input  wire logic                 issue_valid,
  input  wire logic [15:0]          issue_hw0,
  input  wire logic [15:0]          issue_hw1,
  input  wire logic                 branch_taken,
  input  wire logic                 target_io_port,
  input  wire logic                 mem_wait,
  // ----------------------------------------------------------------
  // retire report
  // ----------------------------------------------------------------
  output logic                      busy,
  output logic                      retire_valid,
  output ictim_pkg::ictim_class_t   retire_class,
  output logic [ictim_pkg::CYC_W-1:0] retire_cycles,
  output logic                      retire_fixed,
  output logic                      retire_wide,
  output logic                      undefined
);
  import ictim_pkg::*;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  ictim_class_t      dec_class;
  logic              dec_wide;
  logic [8:0]        dec_list;
  logic [3:0]        list_count;

  ictim_decode u_dec (
    .hw0   (issue_hw0),
    .hw1   (issue_hw1),
    .cls   (dec_class),
    .wide  (dec_wide),
    .rlist (dec_list)
  );

  // extra register counts in the list
  logic [8:0] count_bits;
  assign count_bits = (dec_class == CLS_PUSH || dec_class == CLS_POP) ? dec_list
                    : {1'h0, dec_list[7:0]};

  ictim_popcnt #(.WIDTH(9)) u_pop (
    .bits  (count_bits),
    .count (list_count)
  );

  // ----------------------------------------------------------------
  // expected cycles
  // ----------------------------------------------------------------
  logic [CYC_W-1:0] base_cycles;
  logic             base_fixed;

  always_comb begin
    base_fixed  = 1'h1;
    base_cycles = CYC_ONE;
    case (dec_class)
      CLS_ALU, CLS_ADDR, CLS_EXTEND, CLS_REVERSE, CLS_CPS, CLS_HINT1:
        base_cycles = CYC_ONE;
      CLS_ALU_PC: base_cycles = CYC_TWO;
      CLS_LDST, CLS_LDSTS:
        base_cycles = target_io_port ? CYC_ONE : CYC_TWO;
      CLS_MULTI, CLS_PUSH, CLS_POP:
        base_cycles = CYC_ONE + {1'h0, list_count};
      CLS_BCOND: base_cycles = branch_taken ? CYC_TWO : CYC_ONE;
      CLS_BUNC, CLS_BX, CLS_BLX: base_cycles = CYC_TWO;
      CLS_BLIMM, CLS_SPECREG, CLS_BARRIER: base_cycles = CYC_THREE;
      CLS_WAITHNT: base_cycles = CYC_TWO;
      CLS_SVCALL, CLS_BRKPT: begin
        base_cycles = CYC_NONE;
        base_fixed  = 1'h0;
      end
      default: begin
        base_cycles = CYC_NONE;
        base_fixed  = 1'h0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // execution counter
  // ----------------------------------------------------------------
  typedef enum logic [0:0] {
    ICTIM_IDLE = 1'b0,
    ICTIM_EXEC = 1'b1
  } ictim_state_t;

  ictim_state_t      state;
  ictim_state_t      next_state;
  ictim_class_t      cur_class;
  logic              cur_fixed;
  logic              cur_wide;
  logic [CYC_W-1:0]  remain;
  logic [CYC_W-1:0]  elapsed;

  logic start;
  logic finish;
  logic undef_now;
  assign undef_now = issue_valid && state == ICTIM_IDLE && dec_class == CLS_UNDEF;
  assign start  = issue_valid && state == ICTIM_IDLE && dec_class != CLS_UNDEF;
  // wait states stretch the count
  assign finish = state == ICTIM_EXEC && !mem_wait && remain <= CYC_ONE;

  always_comb begin
    next_state = state;
    case (state)
      ICTIM_IDLE: if (start) next_state = ICTIM_EXEC;
      ICTIM_EXEC: if (finish) next_state = ICTIM_IDLE;
      default:    next_state = ICTIM_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state     <= ICTIM_IDLE;
      cur_class <= CLS_UNDEF;
      cur_fixed <= 1'h0;
      cur_wide  <= 1'h0;
      remain    <= CYC_NONE;
      elapsed   <= CYC_NONE;
    end else begin
      state <= next_state;
      if (start) begin
        cur_class <= dec_class;
        cur_fixed <= base_fixed;
        cur_wide  <= dec_wide;
        remain    <= base_fixed ? base_cycles : CYC_ONE;
        elapsed   <= CYC_ONE;
      end else if (state == ICTIM_EXEC) begin
        elapsed <= elapsed + CYC_ONE;
        if (!mem_wait && remain > CYC_ONE) remain <= remain - CYC_ONE;
      end
    end
  end

  // ----------------------------------------------------------------
  // retire report
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      busy          <= 1'h0;
      retire_valid  <= 1'h0;
      retire_class  <= CLS_UNDEF;
      retire_cycles <= CYC_NONE;
      retire_fixed  <= 1'h0;
      retire_wide   <= 1'h0;
      undefined     <= 1'h0;
    end else begin
      busy         <= next_state == ICTIM_EXEC;
      retire_valid <= finish;
      undefined    <= undef_now;
      if (finish) begin
        retire_class  <= cur_class;
        retire_cycles <= elapsed;
        retire_fixed  <= cur_fixed;
        retire_wide   <= cur_wide;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // stretch of busy cycles seen from outside the counter
  logic [CYC_W-1:0] busy_run;

  always_ff @(posedge clock) begin
    if (rst) begin
      busy_run <= CYC_NONE;
    end else begin
      busy_run <= busy ? busy_run + CYC_ONE : CYC_NONE;
    end
  end

  exec_single_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_ALU |=> (mem_wait || finish))
    else $error("single cycle op did not finish in one cycle");

  exec_load_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_LDST && !target_io_port ##1 !mem_wait
      |-> !finish ##1 (mem_wait || finish))
    else $error("bus load did not take two cycles");

  exec_branch_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_BCOND && !branch_taken |-> ##1 (mem_wait || finish))
    else $error("untaken branch not one cycle");

  exec_bl_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_BLIMM ##1 !mem_wait ##1 !mem_wait
      |-> !finish ##1 (mem_wait || finish))
    else $error("branch with link timing wrong");

  report_cycles_a: assert property (@(posedge clock) disable iff (rst)
    retire_valid |-> retire_cycles == busy_run)
    else $error("retired count differs from busy cycles");

  multi_count_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_MULTI
      |-> base_cycles == CYC_ONE + CYC_W'($countones(issue_hw0[7:0])))
    else $error("multiple transfer count wrong");

  push_lr_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_PUSH && issue_hw0[8]
      |-> base_cycles == CYC_TWO + CYC_W'($countones(issue_hw0[7:0])))
    else $error("link register not counted");

  wait_hint_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_WAITHNT |-> base_cycles == CYC_TWO)
    else $error("wait hint count wrong");

  nofix_svc_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_SVCALL |=> !cur_fixed)
    else $error("supervisor call marked fixed");

  nofix_breakpoint_instr_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_BRKPT |=> !cur_fixed)
    else $error("breakpoint marked fixed");

  addr_single_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_ADDR |=> (mem_wait || finish))
    else $error("address forming not one cycle");

  extend_single_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_EXTEND |=> (mem_wait || finish))
    else $error("extend not one cycle");

  reverse_single_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_REVERSE |=> (mem_wait || finish))
    else $error("byte reverse not one cycle");

  alu_pc_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_ALU_PC ##1 !mem_wait |-> !finish ##1 (mem_wait || finish))
    else $error("pc destination op not two cycles");

  io_access_a: assert property (@(posedge clock) disable iff (rst)
    start && (dec_class == CLS_LDST || dec_class == CLS_LDSTS) && target_io_port
      |=> (mem_wait || finish))
    else $error("io port access not one cycle");

  signed_load_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_LDSTS && !target_io_port ##1 !mem_wait
      |-> !finish ##1 (mem_wait || finish))
    else $error("signed bus load not two cycles");

  taken_branch_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_BCOND && branch_taken ##1 !mem_wait
      |-> !finish ##1 (mem_wait || finish))
    else $error("taken branch not two cycles");

  branch_two_a: assert property (@(posedge clock) disable iff (rst)
    start && (dec_class == CLS_BUNC || dec_class == CLS_BX || dec_class == CLS_BLX)
      ##1 !mem_wait |-> !finish ##1 (mem_wait || finish))
    else $error("branch or exchange not two cycles");

  pop_pc_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_class == CLS_POP && issue_hw0[8]
      |-> base_cycles == CYC_TWO + CYC_W'($countones(issue_hw0[7:0])))
    else $error("program counter not counted");

  wide_only_a: assert property (@(posedge clock) disable iff (rst)
    start && dec_wide |-> dec_class inside {CLS_BLIMM, CLS_SPECREG, CLS_BARRIER})
    else $error("unsupported wide form executed");

  undef_pulse_a: assert property (@(posedge clock) disable iff (rst)
    undef_now |=> undefined && !busy)
    else $error("unsupported form not flagged");

  wait_stretch_a: assert property (@(posedge clock) disable iff (rst)
    busy && mem_wait |=> busy && !retire_valid)
    else $error("wait state did not stretch execution");

  retire_pulse_a: assert property (@(posedge clock) disable iff (rst)
    retire_valid |=> !retire_valid)
    else $error("retire pulse longer than one cycle");

  cover_load_c:   cover property (@(posedge clock) start && dec_class == CLS_LDST);
  cover_push_c:   cover property (@(posedge clock) start && dec_class == CLS_PUSH);
  cover_branch_c: cover property (@(posedge clock) start && dec_class == CLS_BCOND);
  cover_undef_c:  cover property (@(posedge clock) undef_now);
  cover_stall_c:  cover property (@(posedge clock) busy && mem_wait);
endmodule

// File: src/ictim_pkg.sv
package ictim_pkg;

  // ----------------------------------------------------------------
  // instruction classes
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CLS_UNDEF   = 5'h00,
    CLS_ALU     = 5'h01,
    CLS_ALU_PC  = 5'h02,
    CLS_ADDR    = 5'h03,
    CLS_LDST    = 5'h04,
    CLS_LDSTS   = 5'h05,
    CLS_MULTI   = 5'h06,
    CLS_PUSH    = 5'h07,
    CLS_POP     = 5'h08,
    CLS_BCOND   = 5'h09,
    CLS_BUNC    = 5'h0a,
    CLS_BX      = 5'h0b,
    CLS_BLX     = 5'h0c,
    CLS_BLIMM   = 5'h0d,
    CLS_EXTEND  = 5'h0e,
    CLS_REVERSE = 5'h0f,
    CLS_SVCALL  = 5'h10,
    CLS_BRKPT   = 5'h11,
    CLS_CPS     = 5'h12,
    CLS_SPECREG = 5'h13,
    CLS_HINT1   = 5'h14,
    CLS_WAITHNT = 5'h15,
    CLS_BARRIER = 5'h16
  } ictim_class_t;

  // ----------------------------------------------------------------
  // cycle counts and widths
  // ----------------------------------------------------------------
  localparam int          CYC_W       = 5;
  localparam logic [4:0]  CYC_ONE     = 5'h01;
  localparam logic [4:0]  CYC_TWO     = 5'h02;
  localparam logic [4:0]  CYC_THREE   = 5'h03;
  localparam logic [4:0]  CYC_NONE    = 5'h00;
  localparam int          LIST_W      = 4;
  localparam logic [15:0] WIDE_MASK   = 16'hf800;
  localparam logic [15:0] WIDE_PFX0   = 16'he800;
  localparam logic [15:0] WIDE_PFX1   = 16'hf000;
  localparam logic [15:0] WIDE_PFX2   = 16'hf800;

endpackage

// File: src/ictim_popcnt.sv
`timescale 1ns/100ps
module ictim_popcnt #(
  parameter int WIDTH = 9
) (
  // ----------------------------------------------------------------
  // register list in, count out
  // ----------------------------------------------------------------
  input  wire logic [WIDTH-1:0] bits,
  output logic      [3:0]       count
);
  logic [3:0] part [WIDTH:0];
  assign part[0] = 4'h0;
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_add
      assign part[g+1] = part[g] + {3'h0, bits[g]};
    end
  endgenerate
  assign count = part[WIDTH];
endmodule

// File: src/ictim_decode.sv
`timescale 1ns/100ps
module ictim_decode
  import ictim_pkg::*;
(
  // ----------------------------------------------------------------
  // halfwords
  // ----------------------------------------------------------------
  input  wire logic [15:0]  hw0,
  input  wire logic [15:0]  hw1,
  // ----------------------------------------------------------------
  // result
  // ----------------------------------------------------------------
  output ictim_class_t      cls,
  output logic              wide,
  output logic [8:0]        rlist
);
  // ----------------------------------------------------------------
  // narrow and wide decode
  // ----------------------------------------------------------------
  logic is_wide;
  assign is_wide = ((hw0 & WIDE_MASK) == WIDE_PFX0) || ((hw0 & WIDE_MASK) == WIDE_PFX1)
                   || ((hw0 & WIDE_MASK) == WIDE_PFX2);
  assign wide    = is_wide;
  assign rlist   = {hw0[8], hw0[7:0]};

  always_comb begin
    cls = CLS_UNDEF;
    if (is_wide) begin
      // only the six wide forms exist
      if (hw0[15:11] == 5'h1e && hw1[15:14] == 2'h3 && hw1[12] == 1'h1)
        cls = CLS_BLIMM;
      else if (hw0[15:4] == 12'hf3b && hw1[15:8] == 8'h8f && hw1[7:6] == 2'h1)
        cls = CLS_BARRIER;
      else if (hw0[15:5] == 11'h79c && hw1[15:14] == 2'h2)
        cls = CLS_SPECREG;
      else if (hw0[15:0] == 16'hf3ef && hw1[15:12] == 4'h8)
        cls = CLS_SPECREG;
    end else begin
      // narrow set, minus compare-branch and if-then
      case (hw0[15:12])
        4'h0, 4'h1, 4'h2, 4'h3: cls = CLS_ALU;
        4'h4: begin
          if (hw0[11:10] == 2'h0) cls = CLS_ALU;
          else if (hw0[11:10] == 2'h1) begin
            if (hw0[9:8] == 2'h3) cls = hw0[7] ? CLS_BLX : CLS_BX;
            else if (hw0[9:8] != 2'h1 && {hw0[7], hw0[2:0]} == 4'hf)
              cls = CLS_ALU_PC;
            else cls = CLS_ALU;
          end else cls = CLS_LDST;
        end
        4'h5: cls = (hw0[11:9] == 3'h3 || hw0[11:9] == 3'h7) ? CLS_LDSTS : CLS_LDST;
        4'h6, 4'h7, 4'h8, 4'h9: cls = CLS_LDST;
        4'ha: cls = CLS_ADDR;
        4'hb: begin
          case (hw0[11:8])
            4'h0: cls = CLS_ADDR;
            4'h2: cls = CLS_EXTEND;
            4'h4, 4'h5: cls = CLS_PUSH;
            4'hc, 4'hd: cls = CLS_POP;
            4'h6: cls = (hw0[7:5] == 3'h3) ? CLS_CPS : CLS_UNDEF;
            4'ha: cls = (hw0[7:6] != 2'h2) ? CLS_REVERSE : CLS_UNDEF;
            4'he: cls = CLS_BRKPT;
            4'hf: begin
              if (hw0[3:0] != 4'h0) cls = CLS_UNDEF;
              else if (hw0[7:4] == 4'h2 || hw0[7:4] == 4'h3) cls = CLS_WAITHNT;
              else cls = CLS_HINT1;
            end
            default: cls = CLS_UNDEF;
          endcase
        end
        4'hc: cls = CLS_MULTI;
        4'hd: begin
          if (hw0[11:8] == 4'hf) cls = CLS_SVCALL;
          else if (hw0[11:8] == 4'he) cls = CLS_UNDEF;
          else cls = CLS_BCOND;
        end
        4'he: cls = CLS_BUNC;
        default: cls = CLS_UNDEF;
      endcase
    end
  end
endmodule

// File: testbench/ictim_mem_model.sv
`timescale 1ns/100ps
module ictim_mem_model (
  // ----------------------------------------------------------------
  // clock and reset
  // ----------------------------------------------------------------
  input  wire logic       clock,
  input  wire logic       rst,
  // ----------------------------------------------------------------
  // core side
  // ----------------------------------------------------------------
  input  wire logic       busy,
  input  wire logic [3:0] stall_len,
  output logic            mem_wait
);
  logic [3:0] waited;

  // wait states at the start of each execution
  assign mem_wait = busy && (waited < stall_len);

  always_ff @(posedge clock) begin
    if (rst || !busy) begin
      waited <= 4'h0;
    end else if (mem_wait) begin
      waited <= waited + 4'h1;
    end
  end
endmodule

// File: testbench/ictim_top_test.sv
`timescale 1ns/100ps
module ictim_top_test;
  import ictim_pkg::*;
  logic         clock;
  logic         rst;
  logic         issue_valid;
  logic [15:0]  issue_hw0;
  logic [15:0]  issue_hw1;
  logic         branch_taken;
  logic         target_io_port;
  logic         mem_wait;
  logic [3:0]   stall_len;
  logic         busy;
  logic         retire_valid;
  ictim_class_t retire_class;
  logic [4:0]   retire_cycles;
  logic         retire_fixed;
  logic         retire_wide;
  logic         undefined;
  int           bad_count;
  int           total_checks;

  ictim_top u_ictim_top (.clock(clock), .rst(rst), .issue_valid(issue_valid),
    .issue_hw0(issue_hw0), .issue_hw1(issue_hw1), .branch_taken(branch_taken),
    .target_io_port(target_io_port), .mem_wait(mem_wait), .busy(busy),
    .retire_valid(retire_valid), .retire_class(retire_class), .retire_cycles(retire_cycles),
    .retire_fixed(retire_fixed), .retire_wide(retire_wide), .undefined(undefined));
  ictim_mem_model u_ictim_mem_model (.clock(clock), .rst(rst), .busy(busy),
    .stall_len(stall_len), .mem_wait(mem_wait));

  // ----------------------------------------------------------------
  // compare tasks
  // ----------------------------------------------------------------
  task automatic check_cls(input string nm, input ictim_class_t e, input ictim_class_t s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic check_num(input string nm, input logic [4:0] e, input logic [4:0] s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic check_bit(input string nm, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done();
    if (bad_count == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // retire wait and one instruction
  // ----------------------------------------------------------------
  task automatic wait_retire(output int n);
    bit done;
    done = 0;
    n = 0;
    for (int k = 0; k < 40 && !done; k++) begin
      #1;
      if (retire_valid === 1'b1) done = 1;
      else begin
        if (busy === 1'b1) n++;
        @(posedge clock);
      end
    end
    check_bit("retire_valid", 1'b1, done);
  endtask
  task automatic run_instr(input logic [15:0] h0, input logic [15:0] h1, input logic tk,
                           input logic io, input ictim_class_t ec, input logic [4:0] ecyc,
                           input logic ef, input logic ew);
    int n;
    @(posedge clock);
    issue_valid    <= 1'b1;
    issue_hw0      <= h0;
    issue_hw1      <= h1;
    branch_taken   <= tk;
    target_io_port <= io;
    @(posedge clock);
    issue_valid <= 1'b0;
    wait_retire(n);
    check_cls("retire_class", ec, retire_class);
    check_num("retire_cycles", ecyc, retire_cycles);
    check_num("busy_cycles", ecyc, n[4:0]);
    check_bit("retire_fixed", ef, retire_fixed);
    check_bit("retire_wide", ew, retire_wide);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_single();
    run_instr(16'h2001, 16'h0000, 0, 0, CLS_ALU, 5'h01, 1, 0);
    run_instr(16'h4348, 16'h0000, 0, 0, CLS_ALU, 5'h01, 1, 0);
    run_instr(16'h4687, 16'h0000, 0, 0, CLS_ALU_PC, 5'h02, 1, 0);
    run_instr(16'h4487, 16'h0000, 0, 0, CLS_ALU_PC, 5'h02, 1, 0);
    run_instr(16'hb001, 16'h0000, 0, 0, CLS_ADDR, 5'h01, 1, 0);
    run_instr(16'ha001, 16'h0000, 0, 0, CLS_ADDR, 5'h01, 1, 0);
    run_instr(16'hb208, 16'h0000, 0, 0, CLS_EXTEND, 5'h01, 1, 0);
    run_instr(16'hba08, 16'h0000, 0, 0, CLS_REVERSE, 5'h01, 1, 0);
    run_instr(16'hbac8, 16'h0000, 0, 0, CLS_REVERSE, 5'h01, 1, 0);
  endtask
  task automatic t_memory();
    run_instr(16'h6808, 16'h0000, 0, 0, CLS_LDST, 5'h02, 1, 0);
    run_instr(16'h6808, 16'h0000, 0, 1, CLS_LDST, 5'h01, 1, 0);
    run_instr(16'h5688, 16'h0000, 0, 0, CLS_LDSTS, 5'h02, 1, 0);
    run_instr(16'h5688, 16'h0000, 0, 1, CLS_LDSTS, 5'h01, 1, 0);
    run_instr(16'h5e88, 16'h0000, 0, 1, CLS_LDSTS, 5'h01, 1, 0);
    run_instr(16'hc806, 16'h0000, 0, 0, CLS_MULTI, 5'h03, 1, 0);
    run_instr(16'hc003, 16'h0000, 0, 0, CLS_MULTI, 5'h03, 1, 0);
    run_instr(16'hb503, 16'h0000, 0, 0, CLS_PUSH, 5'h04, 1, 0);
    run_instr(16'hbd01, 16'h0000, 0, 0, CLS_POP, 5'h03, 1, 0);
    stall_len <= 4'h2;
    run_instr(16'h6808, 16'h0000, 0, 0, CLS_LDST, 5'h04, 1, 0);
    stall_len <= 4'h0;
  endtask
  task automatic t_branch();
    run_instr(16'hd000, 16'h0000, 1, 0, CLS_BCOND, 5'h02, 1, 0);
    run_instr(16'hd000, 16'h0000, 0, 0, CLS_BCOND, 5'h01, 1, 0);
    run_instr(16'he000, 16'h0000, 0, 0, CLS_BUNC, 5'h02, 1, 0);
    run_instr(16'h4700, 16'h0000, 0, 0, CLS_BX, 5'h02, 1, 0);
    run_instr(16'h4780, 16'h0000, 0, 0, CLS_BLX, 5'h02, 1, 0);
    run_instr(16'hf000, 16'hf800, 0, 0, CLS_BLIMM, 5'h03, 1, 1);
  endtask
  task automatic t_misc();
    run_instr(16'hbf30, 16'h0000, 0, 0, CLS_WAITHNT, 5'h02, 1, 0);
    run_instr(16'hbf20, 16'h0000, 0, 0, CLS_WAITHNT, 5'h02, 1, 0);
    run_instr(16'hdf00, 16'h0000, 0, 0, CLS_SVCALL, 5'h01, 0, 0);
    run_instr(16'hbe00, 16'h0000, 0, 0, CLS_BRKPT, 5'h01, 0, 0);
    run_instr(16'hb672, 16'h0000, 0, 0, CLS_CPS, 5'h01, 1, 0);
    run_instr(16'hbf40, 16'h0000, 0, 0, CLS_HINT1, 5'h01, 1, 0);
    run_instr(16'hf3bf, 16'h8f5f, 0, 0, CLS_BARRIER, 5'h03, 1, 1);
    run_instr(16'hf3ef, 16'h8000, 0, 0, CLS_SPECREG, 5'h03, 1, 1);
    run_instr(16'hf380, 16'h8808, 0, 0, CLS_SPECREG, 5'h03, 1, 1);
  endtask
  task automatic t_undef(input logic [15:0] h0, input logic [15:0] h1);
    bit u;
    bit b;
    u = 0;
    b = 0;
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_hw0   <= h0;
    issue_hw1   <= h1;
    @(posedge clock);
    issue_valid <= 1'b0;
    repeat (3) begin
      #1;
      if (undefined === 1'b1) u = 1;
      if (busy !== 1'b0 || retire_valid !== 1'b0) b = 1;
      @(posedge clock);
    end
    check_bit("undefined", 1'b1, u);
    check_bit("executed", 1'b0, b);
  endtask
  task automatic t_refuse();
    int n;
    bit extra;
    extra = 0;
    @(posedge clock);
    issue_valid <= 1'b1;
    issue_hw0   <= 16'hb503;
    @(posedge clock);
    issue_hw0 <= 16'h2001;
    @(posedge clock);
    @(posedge clock);
    issue_valid <= 1'b0;
    wait_retire(n);
    check_cls("refused_class", CLS_PUSH, retire_class);
    check_num("refused_cycles", 5'h04, retire_cycles);
    repeat (3) begin
      @(posedge clock);
      #1;
      if (retire_valid !== 1'b0 || busy !== 1'b0) extra = 1;
    end
    check_bit("refused_extra", 1'b0, extra);
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    #100000;
    bad_count++;
    test_done();
  end
  initial begin
    rst = 1'b1;
    issue_valid = 1'b0;
    issue_hw0 = 16'h0000;
    issue_hw1 = 16'h0000;
    branch_taken = 1'b0;
    target_io_port = 1'b0;
    stall_len = 4'h0;
    bad_count = 0;
    total_checks = 0;
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    #1;
    check_cls("reset_class", CLS_UNDEF, retire_class);
    check_bit("reset_busy", 1'b0, busy);
    check_bit("reset_retire", 1'b0, retire_valid);
    t_single();
    t_memory();
    t_branch();
    t_misc();
    t_undef(16'hb100, 16'h0000);
    t_undef(16'hb900, 16'h0000);
    t_undef(16'hbf08, 16'h0000);
    t_undef(16'hf8d0, 16'h0000);
    t_refuse();
    test_done();
  end
endmodule
